// >>> rtl/ssp_regs.sv
// general setup register bank for two card sockets, with power and pin muxing
`default_nettype none
// Summary of operation
// - card audio input goes straight to the speaker output, untouched
// - ring-out strap low redefines socket b address pins 11:4
// - regular mode shares general pin functions; alternate mode separates them
// - socket b registers sit at the socket a index plus 40h
// - bus reset clears read/write registers unless resume with keep bit set
// - identification bits 7:6 give supported interface type, not inserted card
// - revision bit 3 writable only when unlocked and maker bit clear
// - status bit 7 is inverted general input, or one when pin is otherwise used
// - status bits 6:4 show power on, ready and write protect live
// - status bits 3:2 are inverted card detect pins
// - bits 1:0 show battery detect, or ring input for i/o cards
// - output enable bit zero tri-states the card control outputs
// - auto power bit switches socket power from card detects
// - power enable bit gates vcc and both vpp supplies
// - vpp2 field encodes to switch pair, reserved value gives zero
// - vpp1 field uses same encoding; low output only in alternate mode
// - bit 7 sets on activity timeout with compatibility; bits 6:5 zero
// - bit 4 sets on chosen general input edge when enabled
// - bit 3 sets on debounced card detect change when enabled
// - bit 2 sets on ready rising edge; zero for i/o cards
// - bit 1 sets on battery warning; zero for i/o cards
// - without write-back, reading flags clears those read as one
// - with write-back, writing one clears a flag; irq until all zero
// - registers reached through an index port then a data port
module ssp_regs #(
  parameter logic [1:0] IF_TYPE = 2'h3,
  parameter logic [2:0] REV_LOW = 3'h5,  // arbitrary value
  parameter int DEBOUNCE = ssp_pkg::DEBOUNCE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_index_wr,
  input wire logic i_data_wr,
  input wire logic i_data_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire ssp_pkg::ssp_card_in_t [1:0] i_card,
  input wire logic i_system_bus_reset,
  input wire logic i_power_good_flag,
  input wire logic i_ring_out_led_pin,
  input wire logic [7:0] i_sockb_card_addr_pin,
  input wire logic [1:0] i_io_card,
  input wire logic [1:0] i_ring_enable,
  input wire logic [1:0] i_compat,
  input wire logic [1:0] i_activity_timeout,
  input wire logic i_rev_unlock,
  input wire logic i_maker_rev_bit,
  input wire logic [1:0][2:0] i_gp_pin_select,
  input wire logic [1:0] i_gp_out_prog_cs,
  input wire logic [7:0] i_sockb_card_addr_11_4,
  input wire logic i_card_audio_in,
  output logic o_speaker_out,
  output ssp_pkg::ssp_vpp_t [1:0] o_vpp,
  output logic [1:0] o_vcc_en,
  output logic [1:0] o_card_ctl_oe,
  output logic [1:0] o_status_change_irq,
  output logic o_alt_pin_mode,
  output logic [7:0] o_sockb_card_addr_11_4,
  output logic [7:0] o_sockb_card_addr_oe,
  output logic [1:0] o_gpio_out,
  output logic [1:0] o_gpio_oe,
  output logic o_chip_select_n
);
  import ssp_pkg::*;
  localparam int SYNC_W = 7 * 2 + 3;
  localparam int CNT_W = $clog2(DEBOUNCE + 1);
  function automatic logic [1:0] vpp_encode(input logic [1:0] field, input logic on);
    vpp_encode = (on && field != VPP_RSVD) ? field : 2'h0;
  endfunction : vpp_encode
  // pin synchronisers; stage 1 feeds stage 2 only
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] next_sync_in;
  ssp_card_in_t [1:0] card;
  ssp_card_in_t [1:0] card_d;
  logic bus_rst;
  logic bus_rst_d;
  logic pg;
  logic strap;
  logic cs_pin;
  assign next_sync_in = {i_card, i_system_bus_reset, i_power_good_flag,
                         i_sockb_card_addr_pin[2]};
  assign card = sync2[SYNC_W-1:3];
  assign bus_rst = sync2[2];
  assign pg = sync2[1];
  assign cs_pin = sync2[0];
  always_ff @(posedge i_ref_clk)
  begin
    sync1 <= next_sync_in;
    sync2 <= sync1;
    card_d <= card;
    bus_rst_d <= bus_rst;
  end
  // strap sampled as a plain level; latched at reset release and at the end of a bus reset
  logic strap_s1;
  logic strap_s2;
  logic srst_d;
  always_ff @(posedge i_ref_clk)
  begin
    strap_s1 <= i_ring_out_led_pin;
    strap_s2 <= strap_s1;
    srst_d <= i_srst;
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      strap <= 1'b0;
    else if (srst_d || (bus_rst_d && !bus_rst))
      strap <= !strap_s2;
  end
  assign o_alt_pin_mode = strap;
  // index port and decode
  logic [7:0] index;
  logic sel;
  logic [5:0] ofs;
  logic bank_ok;
  assign sel = index[SOCK_SEL_BIT];
  assign ofs = index[5:0];
  assign bank_ok = !index[BANK_BIT];
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      index <= REG_RESET;
    else if (i_index_wr)
      index <= i_wdata;
  end
  // per-socket storage
  logic [1:0][7:0] pwr;
  logic [1:0][7:0] cfg;
  logic [1:0][7:0] win;
  logic [1:0][7:0] dgc;
  logic [1:0][7:0] glb;
  logic [1:0] rev3;
  logic [1:0][7:0] csc;
  logic [1:0][7:0] next_csc;
  logic [1:0] wr_s;
  logic [1:0] rd_csc;
  logic [1:0] wr_csc;
  logic [1:0] bus_clr;
  // a resume reset spares a socket whose keep bit is set
  always_comb
  begin
    for (int s = 0; s < 2; s++)
    begin
      wr_s[s] = i_data_wr && bank_ok && (sel == s[0]);
      rd_csc[s] = i_data_rd && bank_ok && (sel == s[0]) && ofs == OFS_CSC;
      wr_csc[s] = wr_s[s] && ofs == OFS_CSC;
      bus_clr[s] = bus_rst && !(pg && pwr[s][PWR_KEEP]);
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    for (int s = 0; s < 2; s++)
    begin
      if (i_srst || bus_clr[s])
      begin
        pwr[s] <= REG_RESET;
        cfg[s] <= REG_RESET;
        win[s] <= REG_RESET;
        dgc[s] <= REG_RESET;
        glb[s] <= REG_RESET;
        rev3[s] <= 1'b0;
      end
      else if (wr_s[s])
      begin
        if (ofs == OFS_PWR)
          pwr[s] <= i_wdata;
        else if (ofs == OFS_CSC_CFG)
          cfg[s] <= i_wdata;
        else if (ofs == OFS_WIN)
          win[s] <= i_wdata;
        else if (ofs == OFS_DGC)
          dgc[s] <= i_wdata & DGC_RW_MASK;
        else if (ofs == OFS_GLB)
          glb[s] <= i_wdata;
        else if (ofs == OFS_ID && i_rev_unlock && !i_maker_rev_bit)
          rev3[s] <= i_wdata[3];
      end
    end
  end
  // card detect debounce; a change must hold for the full window
  logic [1:0][1:0] cd_deb;
  logic [1:0][CNT_W-1:0] cd_cnt;
  logic [1:0] cd_change;
  always_ff @(posedge i_ref_clk)
  begin
    for (int s = 0; s < 2; s++)
    begin
      cd_change[s] <= 1'b0;
      if (i_srst)
      begin
        cd_deb[s] <= 2'h3;
        cd_cnt[s] <= '0;
      end
      else if (card[s].card_detect_n == cd_deb[s])
        cd_cnt[s] <= '0;
      else if (cd_cnt[s] == CNT_W'(DEBOUNCE - 1))
      begin
        cd_deb[s] <= card[s].card_detect_n;
        cd_cnt[s] <= '0;
        cd_change[s] <= 1'b1;
      end
      else
        cd_cnt[s] <= cd_cnt[s] + 1'b1;
    end
  end
  // status change flags; a set in the clearing cycle survives
  logic [1:0][7:0] set_ev;
  logic [1:0][7:0] keep_mask;
  logic [1:0][7:0] clr;
  logic [1:0] gpi_rise;
  logic [1:0] gpi_fall;
  logic [1:0] sw_cd;
  always_comb
  begin
    for (int s = 0; s < 2; s++)
    begin
      gpi_rise[s] = card[s].general_input_n && !card_d[s].general_input_n;
      gpi_fall[s] = !card[s].general_input_n && card_d[s].general_input_n;
      sw_cd[s] = wr_s[s] && ofs == OFS_DGC && i_wdata[DGC_SWCD];
      set_ev[s] = '0;
      set_ev[s][CSC_TMO] = i_activity_timeout[s] && i_compat[s];
      set_ev[s][CSC_GPI] = dgc[s][DGC_GPI_EDGE] ? gpi_rise[s] : gpi_fall[s];
      set_ev[s][CSC_CD] = cd_change[s] || sw_cd[s];
      set_ev[s][CSC_RDY] = card[s].ready && !card_d[s].ready;
      set_ev[s][CSC_BW] = (card[s].battery_volt_detect == BVD_WARN)
                          && (card_d[s].battery_volt_detect != BVD_WARN);
      set_ev[s][CSC_BD] = !card[s].battery_volt_detect[0]
                          && card_d[s].battery_volt_detect[0];
      keep_mask[s] = '0;
      keep_mask[s][CSC_TMO] = 1'b1;
      keep_mask[s][CSC_GPI] = dgc[s][DGC_GPI_EN];
      keep_mask[s][CSC_CD] = cfg[s][CFG_CD];
      keep_mask[s][CSC_RDY] = cfg[s][CFG_RDY] && !i_io_card[s];
      keep_mask[s][CSC_BW] = cfg[s][CFG_BW] && !i_io_card[s];
      keep_mask[s][CSC_BD] = i_io_card[s] ? !i_ring_enable[s] : cfg[s][CFG_BD];
      if (glb[s][GLB_EWB])
        clr[s] = wr_csc[s] ? (i_wdata & csc[s]) : '0;
      else
        clr[s] = rd_csc[s] ? csc[s] : '0;
      next_csc[s] = ((csc[s] & ~clr[s]) | set_ev[s]) & keep_mask[s];
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    for (int s = 0; s < 2; s++)
    begin
      if (i_srst || bus_clr[s])
        csc[s] <= REG_RESET;
      else
        csc[s] <= next_csc[s];
    end
  end
  // irq stays high while any flag is one
  assign o_status_change_irq = {|csc[1], |csc[0]};
  // power gating and supply switch encoding
  logic [1:0] vcc_on;
  ssp_vpp_t [1:0] next_vpp;
  always_comb
  begin
    for (int s = 0; s < 2; s++)
    begin
      vcc_on[s] = pwr[s][PWR_EN]
                  && (!pwr[s][PWR_AUTO] || cd_deb[s] == 2'h0);
      next_vpp[s].vpp2_switch_ctl = vpp_encode(pwr[s][3:2], vcc_on[s]);
      next_vpp[s].vpp1_switch_ctl = vpp_encode(pwr[s][1:0], vcc_on[s]);
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_vpp <= '0;
      o_vcc_en <= '0;
    end
    else
    begin
      o_vpp <= next_vpp;
      o_vcc_en <= vcc_on;
    end
  end

  assign o_card_ctl_oe = {pwr[1][PWR_OE], pwr[0][PWR_OE]};

  // status register view
  logic [1:0][7:0] ifs;
  logic [1:0] gp_bit;
  always_comb
  begin
    for (int s = 0; s < 2; s++)
    begin
      gp_bit[s] = (strap || i_gp_pin_select[s] == GP_PIN_SELECT_IN)
                  ? !card[s].general_input_n : 1'b1;
      ifs[s] = {gp_bit[s], vcc_on[s], card[s].ready, card[s].wp,
                ~card[s].card_detect_n,
                card[s].battery_volt_detect};
    end
  end

  // read mux; unmapped indices read zero
  logic [7:0] rd_val;
  always_comb
  begin
    rd_val = REG_RESET;
    if (!bank_ok)
      rd_val = REG_RESET;
    else if (ofs == OFS_ID)
      rd_val = {IF_TYPE, 2'h0, i_maker_rev_bit | (i_rev_unlock & rev3[sel]), REV_LOW};
    else if (ofs == OFS_IFS)
      rd_val = ifs[sel];
    else if (ofs == OFS_PWR)
      rd_val = pwr[sel];
    else if (ofs == OFS_CSC)
      rd_val = csc[sel];
    else if (ofs == OFS_CSC_CFG)
      rd_val = cfg[sel];
    else if (ofs == OFS_WIN)
      rd_val = win[sel];
    else if (ofs == OFS_DGC)
      rd_val = dgc[sel];
    else if (ofs == OFS_GLB)
      rd_val = glb[sel];
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      o_rdata <= REG_RESET;
    else if (i_data_rd)
      o_rdata <= rd_val;
  end

  // audio is a pure wire so no retiming skew is added
  assign o_speaker_out = i_card_audio_in;

  // socket b address pins, alternate definition under low strap
  logic [7:0] alt_pins;
  assign alt_pins = {next_vpp[0].vpp2_switch_ctl[0], next_vpp[0].vpp1_switch_ctl[0],
                     next_vpp[1].vpp2_switch_ctl[0], next_vpp[1].vpp1_switch_ctl[0],
                     !pwr[1][PWR_OE], 1'b0, i_gp_out_prog_cs[0], i_gp_out_prog_cs[1]};
  assign o_sockb_card_addr_11_4 = strap ? alt_pins : i_sockb_card_addr_11_4;
  assign o_sockb_card_addr_oe = strap ? 8'hfb : 8'hff;

  // general pin sharing in the regular definition only
  always_comb
  begin
    for (int s = 0; s < 2; s++)
    begin
      o_gpio_oe[s] = !strap && i_gp_pin_select[s] == GP_PIN_SELECT_OUT;
      o_gpio_out[s] = i_gp_out_prog_cs[s];
    end
  end
  assign o_chip_select_n = strap ? cs_pin
                         : (i_gp_pin_select[0] == GP_PIN_SELECT_CS ? card[0].general_input_n : 1'b1);

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  AST_AUDIO_PASS: assert property (o_speaker_out == i_card_audio_in)
    else $error("speaker output differs from card audio");
  AST_ALT_CS_IN: assert property (o_alt_pin_mode |-> o_sockb_card_addr_oe[2] == 1'b0)
    else $error("chip select pin driven in alternate mode");
  AST_SOCKB_WRITE: assert property (
    (i_data_wr && index == 8'h42 && !bus_rst) |=> pwr[1] == $past(i_wdata))
    else $error("socket b power register not written at 42h");
  AST_BUS_RESET: assert property (
    (bus_rst && !pg && !i_srst) |=> (pwr[0] == 8'h00 && csc[0] == 8'h00))
    else $error("bus reset left registers set");
  AST_CD_VIEW: assert property (
    (i_data_rd && index == 8'h01) |=> o_rdata[3:2] == ~$past(card[0].card_detect_n))
    else $error("card detect status wrong");
  AST_OE_GATE: assert property (
    (i_data_wr && index == 8'h02 && !bus_rst) |=> o_card_ctl_oe[0] == $past(i_wdata[7]))
    else $error("output enable not following power control");
  AST_VPP_OFF: assert property (!vcc_on[0] |=> o_vpp[0] == '0 && !o_vcc_en[0])
    else $error("supply on while power disabled");
  AST_VPP_RSVD: assert property (
    (pwr[0][3:2] == 2'h3) |=> o_vpp[0].vpp2_switch_ctl == 2'h0)
    else $error("reserved vpp2 code drives switch");
  AST_CD_MASK: assert property (!cfg[0][CFG_CD] |=> !csc[0][CSC_CD])
    else $error("card detect change set while disabled");
  AST_READ_CLEAR: assert property (
    (rd_csc[0] && !glb[0][GLB_EWB] && set_ev[0] == '0) |=> csc[0] == 8'h00)
    else $error("flags not cleared by read");
  AST_TMO_SET: assert property (
    (i_activity_timeout[0] && i_compat[0] && !bus_clr[0]) |=> csc[0][CSC_TMO]
      && csc[0][6:5] == 2'h0)
    else $error("activity timeout flag missing");
endmodule : ssp_regs
`default_nettype wire

// >>> rtl/ssp_pkg.sv
// shared constants and types of the socket status and power register bank
`default_nettype none
package ssp_pkg;
  // register offsets within one socket block
  localparam logic [5:0] OFS_ID = 6'h00;
  localparam logic [5:0] OFS_IFS = 6'h01;
  localparam logic [5:0] OFS_PWR = 6'h02;
  localparam logic [5:0] OFS_CSC = 6'h04;
  localparam logic [5:0] OFS_CSC_CFG = 6'h05;
  localparam logic [5:0] OFS_WIN = 6'h06;
  localparam logic [5:0] OFS_DGC = 6'h16;
  localparam logic [5:0] OFS_GLB = 6'h1e;
  // index bit that selects socket b (base + 40h)
  localparam int SOCK_SEL_BIT = 6;
  localparam int BANK_BIT = 7;
  localparam logic [7:0] REG_RESET = 8'h00;
  // power control fields
  localparam int PWR_OE = 7;
  localparam int PWR_KEEP = 6;
  localparam int PWR_AUTO = 5;
  localparam int PWR_EN = 4;
  // status change flag positions
  localparam int CSC_TMO = 7;
  localparam int CSC_GPI = 4;
  localparam int CSC_CD = 3;
  localparam int CSC_RDY = 2;
  localparam int CSC_BW = 1;
  localparam int CSC_BD = 0;
  // status change enable positions
  localparam int CFG_CD = 3;
  localparam int CFG_RDY = 2;
  localparam int CFG_BW = 1;
  localparam int CFG_BD = 0;
  // detect and general control fields
  localparam int DGC_SWCD = 5;
  localparam int DGC_GPI_EDGE = 3;
  localparam int DGC_GPI_EN = 2;
  localparam logic [7:0] DGC_RW_MASK = 8'h1f;
  localparam int GLB_EWB = 1;
  // general-purpose pin select codes
  localparam logic [2:0] GP_PIN_SELECT_IN = 3'h0;
  localparam logic [2:0] GP_PIN_SELECT_OUT = 3'h1;
  localparam logic [2:0] GP_PIN_SELECT_CS = 3'h2;
  localparam logic [1:0] VPP_RSVD = 2'h3;
  localparam logic [1:0] BVD_WARN = 2'h1;
  // card detect debounce time
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEBOUNCE_NS = 10000;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [1:0] card_detect_n;
    logic ready;
    logic wp;
    logic [1:0] battery_volt_detect;
    logic general_input_n;
  } ssp_card_in_t;

  typedef struct packed {
    logic [1:0] vpp1_switch_ctl;
    logic [1:0] vpp2_switch_ctl;
  } ssp_vpp_t;
endpackage : ssp_pkg
`default_nettype wire

// >>> dv/ssp_card_model.sv
// behavioural pc card sitting in one socket
`default_nettype none
module ssp_card_model (
  input wire logic i_present,
  input wire logic i_vcc,
  input wire logic i_ready,
  input wire logic i_wp,
  input wire logic [1:0] i_bvd,
  input wire logic i_gpi_n,
  input wire logic i_audio,
  output ssp_pkg::ssp_card_in_t o_card,
  output logic o_audio
);
  timeunit 1ns;
  timeprecision 100ps;
  import ssp_pkg::*;
  // empty socket: status lines other than the general input float up to their pull-ups
  always_comb
  begin
    o_card.card_detect_n = i_present ? 2'h0 : 2'h3;
    // unpowered card stays busy
    o_card.ready = i_present ? (i_vcc & i_ready) : 1'h1;
    o_card.wp = i_present ? i_wp : 1'h1;
    o_card.battery_volt_detect = i_present ? i_bvd : 2'h3;
    o_card.general_input_n = i_gpi_n;
    o_audio = i_present ? i_audio : 1'h1;
  end
endmodule : ssp_card_model
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench of the socket status and power register bank
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import ssp_pkg::*;
  logic clk, srst, idx_wr, d_wr, d_rd, bus_rst, pgood, strap, unlock, maker, audio, alt, spk;
  logic [7:0] wdata, addr_in, addr_pin, rdata, ca_out, ca_oe;
  logic [1:0] io, ringen, compat, act, gpo, pres, rdy, wpv, gpin, bvda;
  logic [1:0] vcc, oe, irq, gp_out, gp_oe;
  logic [1:0][2:0] sel;
  ssp_card_in_t card_a, card_b;
  ssp_vpp_t [1:0] vpp;
  logic audio_a, csn;
  int bad_count, compares, cycles;

  ssp_card_model card0 (.i_present(pres[0]), .i_vcc(vcc[0]), .i_ready(rdy[0]), .i_wp(wpv[0]),
    .i_bvd(bvda), .i_gpi_n(gpin[0]), .i_audio(audio), .o_card(card_a), .o_audio(audio_a));
  ssp_card_model card1 (.i_present(pres[1]), .i_vcc(vcc[1]), .i_ready(1'h1), .i_wp(1'h1),
    .i_bvd(2'h3), .i_gpi_n(gpin[1]), .i_audio(1'h1), .o_card(card_b), .o_audio());

  ssp_regs #(.DEBOUNCE(4)) dut (.i_ref_clk(clk), .i_srst(srst), .i_index_wr(idx_wr),
    .i_data_wr(d_wr), .i_data_rd(d_rd), .i_wdata(wdata), .o_rdata(rdata),
    .i_card({card_b, card_a}), .i_system_bus_reset(bus_rst), .i_power_good_flag(pgood),
    .i_ring_out_led_pin(strap), .i_sockb_card_addr_pin(addr_pin), .i_io_card(io),
    .i_ring_enable(ringen), .i_compat(compat), .i_activity_timeout(act),
    .i_rev_unlock(unlock), .i_maker_rev_bit(maker), .i_gp_pin_select(sel),
    .i_gp_out_prog_cs(gpo), .i_sockb_card_addr_11_4(addr_in), .i_card_audio_in(audio_a),
    .o_speaker_out(spk), .o_vpp(vpp), .o_vcc_en(vcc), .o_card_ctl_oe(oe),
    .o_status_change_irq(irq), .o_alt_pin_mode(alt), .o_sockb_card_addr_11_4(ca_out),
    .o_sockb_card_addr_oe(ca_oe), .o_gpio_out(gp_out), .o_gpio_oe(gp_oe), .o_chip_select_n(csn));

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    idx_wr <= 1'h1;
    wdata <= idx;
    @(posedge clk);
    idx_wr <= 1'h0;
    d_wr <= 1'h1;
    wdata <= d;
    @(posedge clk);
    d_wr <= 1'h0;
  endtask : wr

  // o_rdata is settled just after the read edge; ends on an edge for later stimulus
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge clk);
    idx_wr <= 1'h1;
    wdata <= idx;
    @(posedge clk);
    idx_wr <= 1'h0;
    d_rd <= 1'h1;
    @(posedge clk);
    d_rd <= 1'h0;
    #1 chk(rdata, exp);
    @(posedge clk);
  endtask : rdc

  function automatic logic [1:0] vmap(input logic [1:0] c);
    return (c == 2'h3) ? 2'h0 : c;
  endfunction : vmap

  task automatic t_id();
    logic [7:0] ofs [5] = '{8'h02, 8'h04, 8'h06, 8'h16, 8'h1e};
    for (int i = 0; i < 5; i++)
    begin
      rdc(ofs[i], 8'h00);
      rdc(ofs[i] | 8'h40, 8'h00);
    end
    wr(8'h82, 8'hff);
    rdc(8'h02, 8'h00);
    rdc(8'h00, 8'hc5);
    wr(8'h00, 8'h08);
    rdc(8'h00, 8'hc5);
    unlock <= 1'h1;
    wr(8'h00, 8'h08);
    rdc(8'h00, 8'hcd);
    rdc(8'h40, 8'hc5);
    wr(8'h00, 8'h00);
    maker <= 1'h1;
    rdc(8'h00, 8'hcd);
    maker <= 1'h0;
    unlock <= 1'h0;
    $display("test id done");
  endtask : t_id

  task automatic t_power();
    for (int i = 0; i < 16; i++)
    begin
      wr(8'h02, 8'h10 | 8'(i));
      cyc(3);
      chk(8'(vpp[0]), {4'h0, vmap(i[1:0]), vmap(i[3:2])});
    end
    wr(8'h02, 8'h0b);
    cyc(3);
    chk({vpp[0], 2'h0, vcc[0], 1'h0}, 8'h00);
    wr(8'h02, 8'h10);
    cyc(3);
    chk({6'h0, oe[0], vcc[0]}, 8'h01);
    wr(8'h02, 8'h90);
    cyc(3);
    chk({6'h0, oe[0], vcc[0]}, 8'h03);
    wr(8'h02, 8'h30);
    cyc(3);
    chk({7'h0, vcc[0]}, 8'h01);
    pres[0] <= 1'h0;
    cyc(8);
    chk({6'h0, vcc}, 8'h00);
    pres[0] <= 1'h1;
    cyc(8);
    chk({6'h0, vcc}, 8'h01);
    wr(8'h02, 8'h10);
    $display("test power done");
  endtask : t_power

  task automatic t_status();
    wpv[0] <= 1'h1;
    bvda <= 2'h1;
    gpin[0] <= 1'h0;
    cyc(5);
    rdc(8'h01, 8'hfd);
    wpv[0] <= 1'h0;
    bvda <= 2'h2;
    gpin[0] <= 1'h1;
    cyc(5);
    rdc(8'h01, 8'h6e);
    sel[0] <= GP_PIN_SELECT_OUT;
    gpo <= 2'h1;
    rdc(8'h01, 8'hee);
    chk({6'h0, gp_oe[0], gp_out[0]}, 8'h03);
    sel[0] <= GP_PIN_SELECT_CS;
    gpin[0] <= 1'h0;
    cyc(4);
    chk({7'h0, csn}, 8'h00);
    sel[0] <= GP_PIN_SELECT_IN;
    gpin[0] <= 1'h1;
    rdc(8'h41, 8'h33);
    chk({7'h0, gp_oe[0]}, 8'h00);
    chk(ca_out, addr_in);
    chk(ca_oe, 8'hff);
    $display("test status done");
  endtask : t_status

  task automatic t_flags();
    rdy[0] <= 1'h0;
    cyc(6);
    wr(8'h05, 8'h04);
    rdy[0] <= 1'h1;
    cyc(6);
    chk({6'h0, irq}, 8'h01);
    rdc(8'h04, 8'h04);
    rdc(8'h04, 8'h00);
    chk({6'h0, irq}, 8'h00);
    bvda <= 2'h3;
    cyc(6);
    wr(8'h1e, 8'h02);
    wr(8'h05, 8'h02);
    bvda <= BVD_WARN;
    cyc(6);
    rdc(8'h04, 8'h02);
    rdc(8'h04, 8'h02);
    chk({6'h0, irq}, 8'h01);
    wr(8'h04, 8'h02);
    rdc(8'h04, 8'h00);
    chk({6'h0, irq}, 8'h00);
    wr(8'h1e, 8'h00);
    wr(8'h16, 8'h04);
    gpin[0] <= 1'h0;
    cyc(6);
    rdc(8'h04, 8'h10);
    wr(8'h16, 8'h00);
    wr(8'h05, 8'h08);
    pres[0] <= 1'h0;
    cyc(20);
    rdc(8'h04, 8'h08);
    pres[0] <= 1'h1;
    cyc(20);
    rdc(8'h04, 8'h08);
    io[0] <= 1'h1;
    wr(8'h05, 8'h04);
    rdy[0] <= 1'h0;
    cyc(6);
    rdy[0] <= 1'h1;
    cyc(6);
    rdc(8'h04, 8'h00);
    io[0] <= 1'h0;
    wr(8'h05, 8'h00);
    compat[0] <= 1'h1;
    act[0] <= 1'h1;
    cyc(1);
    act[0] <= 1'h0;
    cyc(4);
    rdc(8'h04, 8'h80);
    compat[0] <= 1'h0;
    act[0] <= 1'h1;
    cyc(1);
    act[0] <= 1'h0;
    cyc(4);
    rdc(8'h04, 8'h00);
    $display("test flags done");
  endtask : t_flags

  task automatic t_reset();
    wr(8'h02, 8'h50);
    wr(8'h06, 8'h5a);
    wr(8'h46, 8'ha5);
    pgood <= 1'h1;
    bus_rst <= 1'h1;
    cyc(4);
    bus_rst <= 1'h0;
    cyc(4);
    rdc(8'h02, 8'h50);
    rdc(8'h06, 8'h5a);
    rdc(8'h46, 8'h00);
    pgood <= 1'h0;
    strap <= 1'h0;
    bus_rst <= 1'h1;
    cyc(4);
    bus_rst <= 1'h0;
    cyc(6);
    rdc(8'h02, 8'h00);
    rdc(8'h06, 8'h00);
    chk({7'h0, alt}, 8'h01);
    $display("test reset done");
  endtask : t_reset

  task automatic t_alt();
    wr(8'h02, 8'h15);
    wr(8'h42, 8'h9a);
    gpo <= 2'h1;
    cyc(3);
    chk(ca_out & 8'hfb, 8'hc2);
    chk(ca_oe, 8'hfb);
    chk({6'h0, gp_oe}, 8'h00);
    chk(8'(vpp[1]), 8'h0a);
    chk({7'h0, csn}, 8'h00);
    addr_pin <= 8'h04;
    cyc(3);
    chk({7'h0, csn}, 8'h01);
    @(posedge clk);
    audio <= 1'h0;
    #1 chk({7'h0, spk}, 8'h00);
    @(posedge clk);
    audio <= 1'h1;
    #1 chk({7'h0, spk}, 8'h01);
    $display("test alt done");
  endtask : t_alt

  initial
  begin
    {srst, strap, rdy, pres, gpin} = 8'hff;
    {idx_wr, d_wr, d_rd, bus_rst, pgood, unlock, maker, audio} = 8'h00;
    {wdata, addr_pin, io, ringen, compat, act, gpo, wpv, bvda} = 30'h0;
    pres[1] = 1'h0;
    addr_in = 8'h3c;
    sel = '0;
    cyc(8);
    srst <= 1'h0;
    cyc(1);
    t_id();
    t_power();
    t_status();
    t_flags();
    t_reset();
    t_alt();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
